// ==== rtl/flash_cmd_pkg.sv ====
// Purpose: Constants for the serial flash latch, ident, security and lock commands
// Assumes: One serial lane; single-lane answers for all read-type commands
// Contract
// - Latch-set opcode alone in a frame sets the write latch
// - Content-changing commands are refused unless the write latch is set
// - Latch-clear opcode alone in a frame clears the write latch
// - Write latch is clear after reset
// - Program and erase completion clears the write latch
// - Status, protect-select, security and lock completion clear the write latch
// - Ident opcode returns maker byte then two part bytes, msb first
// - Select high stops output driving at once
// - Ident opcode not decoded while program or erase is busy
// - Select high returns the interface to standby
// - Maker-part reads: address 00 gives maker first, 01 part first
// - Security read opcode without address returns the security register
// - Security write sets lock-down bit, which never clears again; the code clears it on reset
// - Lock-status read with three address bytes returns that block's lock
// - Whole lock protects all blocks, whole unlock frees all, no address
// - Busy flag is 1 during program, erase or status write
package flash_cmd_pkg;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STATUS_WR = 8'h01;
    localparam logic [7:0] OP_SECTOR_ER = 8'h20;
    localparam logic [7:0] OP_HALF_ER = 8'h52;
    localparam logic [7:0] OP_BLOCK_ER = 8'hD8;
    localparam logic [7:0] OP_CHIP_ER_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ER_B = 8'hC7;
    localparam logic [7:0] OP_PAGE_WR = 8'h02;
    localparam logic [7:0] OP_QUAD_WR = 8'h38;
    localparam logic [7:0] OP_IDENT = 8'h9F;
    localparam logic [7:0] OP_PART = 8'hAB;
    localparam logic [7:0] OP_MP = 8'h90;
    localparam logic [7:0] OP_MP_DUAL = 8'hEF;
    localparam logic [7:0] OP_MP_QUAD = 8'hDF;
    localparam logic [7:0] OP_SEC_RD = 8'h2B;
    localparam logic [7:0] OP_SEC_WR = 8'h2F;
    localparam logic [7:0] OP_ONE_LOCK = 8'h36;
    localparam logic [7:0] OP_ONE_UNLOCK = 8'h39;
    localparam logic [7:0] OP_LOCK_RD = 8'h3C;
    localparam logic [7:0] OP_ALL_LOCK = 8'h7E;
    localparam logic [7:0] OP_ALL_UNLOCK = 8'h98;
    localparam logic [7:0] OP_PROT_SEL = 8'h68;
    // Frame lengths in whole bytes, opcode included
    localparam logic [3:0] NB_ZERO = 4'h0;
    localparam logic [3:0] NB_CMD = 4'h1;
    localparam logic [3:0] NB_STATUS_WR = 4'h2;
    localparam logic [3:0] NB_ADDR_CMD = 4'h4;
    localparam logic [3:0] NB_SAT = 4'hF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] ID_ORDER_PART = 8'h01;
    localparam logic [1:0] RING_ID_LAST = 2'h2;
    localparam logic [1:0] RING_MP_LAST = 2'h1;
    localparam logic [1:0] RING_FIRST = 2'h0;
    localparam logic [1:0] RING_SECOND = 2'h1;
    localparam int SEC_LOCK_BIT = 1;
    localparam int SEC_PSEL_BIT = 7;
    localparam logic [7:0] SEC_RST = 8'h00;
    localparam int BLK_LSB = 16;
    localparam logic [7:0] LOCK_BYTE_ON = 8'hFF;
    localparam logic [7:0] LOCK_BYTE_OFF = 8'h00;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } op_state_t;
endpackage

// ==== rtl/bit_sync2.sv ====
// Purpose: Two-flop synchroniser for levels and quasi-static words
// Assumes: Words only change while the far side holds them still
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps
module bit_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule

// ==== rtl/flash_cmd_core.sv ====
// Purpose: Latch, ident, security and block-lock command handling of a serial flash
// Assumes: Program, erase and status write run in an outside engine (wr_req/wr_done)
// Notes: Link counters and output run on sclk and are cleared by select high, frame contents are kept; ce freezes clk_sys state
`timescale 1ns/1ps
module flash_cmd_core
    import flash_cmd_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A,  // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h3C14,  // Arbitrary value
    parameter int NUM_BLOCKS = 16
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    output logic wr_req,
    output logic [7:0] wr_opcode,
    output logic [23:0] wr_addr,
    input wire logic wr_done,
    output logic write_latch,
    output logic busy_flag,
    output logic cmd_reject,
    output logic [7:0] sec_reg,
    output logic [NUM_BLOCKS-1:0] block_lock
);
    localparam int BLK_W = $clog2(NUM_BLOCKS);
    localparam int SYNC_W = 1 + 8 + NUM_BLOCKS;

    // Link side, sclk domain
    logic [2:0] bit_q;
    logic [3:0] byte_q;
    logic [3:0] byte_d;
    logic [1:0] ring_q;
    logic [1:0] ring_d;
    logic [7:0] sh_q;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    logic [3:0] nbytes_q;
    logic algn_q;
    // Toggles once per frame, when the opcode byte ends; the sys side takes its value at reset
    logic tgl_q = 1'b0;
    logic so_q;
    logic oe_n_q;
    logic [SYNC_W-1:0] sys_l;
    logic busy_l;
    logic [7:0] sec_l;
    logic [NUM_BLOCKS-1:0] lock_l;

    wire byte_end = (bit_q == BIT_LAST);
    wire [3:0] byte_inc = (byte_q == NB_SAT) ? NB_SAT : byte_q + NB_CMD;
    wire l_ident = (opcode_q == OP_IDENT);
    wire l_part = (opcode_q == OP_PART);
    wire l_mp = (opcode_q == OP_MP) || (opcode_q == OP_MP_DUAL) || (opcode_q == OP_MP_QUAD);
    wire l_secrd = (opcode_q == OP_SEC_RD);
    wire l_lockrd = (opcode_q == OP_LOCK_RD);
    wire short_rd = (l_ident && !busy_l) || l_secrd;
    wire long_rd = l_part || l_mp || l_lockrd;
    wire out_phase = (short_rd && byte_q >= NB_CMD) || (long_rd && byte_q >= NB_ADDR_CMD);
    wire part_first = (addr_q[7:0] == ID_ORDER_PART);
    wire [BLK_W-1:0] rd_blk = addr_q[BLK_LSB +: BLK_W];
    wire [7:0] id_byte = (ring_q == RING_FIRST) ? MAKER_CODE :
                         (ring_q == RING_SECOND) ? PART_CODE[15:8] : PART_CODE[7:0];
    wire [7:0] mp_byte = ((ring_q == RING_FIRST) != part_first) ? MAKER_CODE : PART_CODE[7:0];
    wire [7:0] lk_byte = lock_l[rd_blk] ? LOCK_BYTE_ON : LOCK_BYTE_OFF;
    wire [7:0] out_byte = l_ident ? id_byte :
                          l_mp ? mp_byte :
                          l_part ? PART_CODE[7:0] :
                          l_secrd ? sec_l : lk_byte;
    wire out_bit = out_byte[BIT_LAST - bit_q];

    assign byte_d = byte_end ? byte_inc : byte_q;
    assign ring_d = (l_ident ? (ring_q == RING_ID_LAST) : (ring_q == RING_MP_LAST)) ?
                    RING_FIRST : ring_q + RING_SECOND;
    assign busy_l = sys_l[0];
    assign sec_l = sys_l[8:1];
    assign lock_l = sys_l[SYNC_W-1:9];

    // Select high clears the frame state: standby between frames
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_q <= '0;
            byte_q <= NB_ZERO;
            ring_q <= RING_FIRST;
        end else begin
            bit_q <= bit_q + 3'h1;
            byte_q <= byte_d;
            if (byte_end && out_phase) begin
                ring_q <= ring_d;
            end
        end
    end

    // Frame contents survive select high so the sys side can commit them
    always_ff @(posedge sclk) begin
        sh_q <= {sh_q[6:0], si};
        nbytes_q <= byte_d;
        algn_q <= byte_end;
        if (byte_end && byte_q == NB_ZERO) begin
            opcode_q <= {sh_q[6:0], si};
            tgl_q <= ~tgl_q;
        end
        if (byte_q != NB_ZERO && byte_q < NB_ADDR_CMD) begin
            addr_q <= {addr_q[22:0], si};
        end
    end

    // Output moves on the falling edge; select high releases it at once
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            so_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            so_q <= out_bit;
            oe_n_q <= ~out_phase;
        end
    end

    assign so = so_q;
    assign so_oe_n = oe_n_q;

    // Quasi-static sys state seen by the link; changes only between frames
    bit_sync2 #(.W(SYNC_W)) u_to_link (
        .clk(sclk),
        .d({block_lock, sec_reg, busy_flag}),
        .q(sys_l)
    );

    // Sys side, clk_sys domain
    logic [1:0] link_s;
    logic cs_d_q;
    logic tgl_seen_q;
    logic latch_q;
    logic latch_d;
    op_state_t st_q;
    op_state_t st_d;
    logic req_q;
    logic rej_q;
    logic [7:0] wop_q;
    logic [23:0] wad_q;
    logic [7:0] sec_q;
    logic [NUM_BLOCKS-1:0] lock_q;

    bit_sync2 #(.W(2)) u_to_sys (
        .clk(clk_sys),
        .d({tgl_q, cs_n}),
        .q(link_s)
    );

    wire cs_s = link_s[0];
    wire tgl_s = link_s[1];
    wire commit = ce && resetn && cs_s && !cs_d_q && (tgl_s != tgl_seen_q);
    wire len1 = algn_q && (nbytes_q == NB_CMD);
    wire len2 = algn_q && (nbytes_q == NB_STATUS_WR);
    wire len4 = algn_q && (nbytes_q == NB_ADDR_CMD);
    wire len_pg = algn_q && (nbytes_q > NB_ADDR_CMD);
    wire c_set = commit && (opcode_q == OP_LATCH_SET) && len1;
    wire c_clr = commit && (opcode_q == OP_LATCH_CLR) && len1;
    wire o_pg = (opcode_q == OP_PAGE_WR) || (opcode_q == OP_QUAD_WR);
    wire o_er = (opcode_q == OP_SECTOR_ER) || (opcode_q == OP_HALF_ER) ||
                (opcode_q == OP_BLOCK_ER);
    wire o_ce = (opcode_q == OP_CHIP_ER_A) || (opcode_q == OP_CHIP_ER_B);
    wire o_sw = (opcode_q == OP_STATUS_WR);
    wire o_one = (opcode_q == OP_ONE_LOCK) || (opcode_q == OP_ONE_UNLOCK);
    wire o_one_lk = (opcode_q == OP_ONE_LOCK);
    wire o_all = (opcode_q == OP_ALL_LOCK) || (opcode_q == OP_ALL_UNLOCK);
    wire o_swr = (opcode_q == OP_SEC_WR);
    wire o_psel = (opcode_q == OP_PROT_SEL);
    wire eng_op = o_pg || o_er || o_ce || o_sw;
    wire loc_op = o_one || o_all || o_swr || o_psel;
    wire eng_len = (o_pg && len_pg) || (o_er && len4) || (o_ce && len1) || (o_sw && len2);
    wire loc_len = (o_one && len4) || ((o_all || o_swr || o_psel) && len1);
    wire may_write = latch_q && (st_q == ST_IDLE);
    wire eng_go = commit && eng_op && eng_len && may_write;
    wire loc_go = commit && loc_op && loc_len && may_write;
    wire rej_go = commit && (eng_op || loc_op) && !(eng_go || loc_go);
    wire eng_done = ce && wr_done && (st_q == ST_BUSY);
    wire [BLK_W-1:0] wr_blk = addr_q[BLK_LSB +: BLK_W];

    // Set wins over every clear arriving in the same cycle
    assign latch_d = c_set ? 1'b1 :
                     (c_clr || loc_go || eng_done) ? 1'b0 : latch_q;
    assign st_d = eng_go ? ST_BUSY : (eng_done ? ST_IDLE : st_q);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cs_d_q <= 1'b1;
            tgl_seen_q <= tgl_s;
            latch_q <= 1'b0;
            st_q <= ST_IDLE;
            req_q <= 1'b0;
            rej_q <= 1'b0;
        end else if (ce) begin
            cs_d_q <= cs_s;
            // Tracked whenever select is high and ce is set: a frame lost while frozen is dropped
            if (cs_s) begin
                tgl_seen_q <= tgl_s;
            end
            latch_q <= latch_d;
            st_q <= st_d;
            req_q <= eng_go;
            rej_q <= rej_go;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wop_q <= '0;
            wad_q <= '0;
            sec_q <= SEC_RST;
            lock_q <= '0;
        end else if (ce) begin
            if (eng_go) begin
                wop_q <= opcode_q;
                wad_q <= addr_q;
            end
            if (loc_go && o_swr) begin
                sec_q[SEC_LOCK_BIT] <= 1'b1;
            end
            if (loc_go && o_psel) begin
                sec_q[SEC_PSEL_BIT] <= 1'b1;
            end
            if (loc_go && o_all) begin
                lock_q <= {NUM_BLOCKS{opcode_q == OP_ALL_LOCK}};
            end
            if (loc_go && o_one) begin
                lock_q[wr_blk] <= o_one_lk;
            end
        end
    end

    assign write_latch = latch_q;
    assign busy_flag = (st_q == ST_BUSY);
    assign wr_req = req_q;
    assign wr_opcode = wop_q;
    assign wr_addr = wad_q;
    assign cmd_reject = rej_q;
    assign sec_reg = sec_q;
    assign block_lock = lock_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_latch_after_reset: assert property ($rose(resetn) |-> !write_latch && !busy_flag)
        else $error("latch not clear after reset");
    a_latch_set_cmd: assert property (c_set |=> write_latch)
        else $error("latch-set did not set latch");
    a_latch_clr_cmd: assert property (c_clr |=> !write_latch)
        else $error("latch-clear did not clear latch");
    a_req_needs_latch: assert property (wr_req |-> $past(write_latch) && !$past(busy_flag))
        else $error("write issued without latch or while busy");
    a_local_needs_latch: assert property ($changed(block_lock) || $changed(sec_reg) |->
        $past(write_latch))
        else $error("lock changed without latch");
    a_done_clears: assert property (eng_done && !c_set |=> !write_latch && !busy_flag)
        else $error("completion left latch or busy set");
    a_local_clears: assert property (loc_go && !c_set |=> !write_latch)
        else $error("local write left latch set");
    a_busy_holds: assert property (wr_req && !wr_done |-> busy_flag ##1 busy_flag)
        else $error("busy not held after write start");
    a_whole_lock: assert property (loc_go && opcode_q == OP_ALL_LOCK |=> &block_lock)
        else $error("whole lock left a block free");
    a_sec_sticky: assert property (sec_reg[SEC_LOCK_BIT] |=> sec_reg[SEC_LOCK_BIT])
        else $error("lock-down bit cleared");
    a_out_released: assert property (cs_n |-> so_oe_n)
        else $error("output driven with select high");

    c_latch_set: cover property (c_set ##[1:200] wr_req);
    c_rejected: cover property (rej_go);
    c_op_done: cover property (eng_done);
endmodule

// ==== testbench/host_model.sv ====
// Purpose: Host side of the serial link, sends frames and collects answer bytes
// Assumes: Link clock idles low and stands still between frames
// Notes: Only defined opcodes are ever sent
`timescale 1ns/1ps
module host_model (
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe_n,
    output logic [7:0] rx_byte,
    output logic rx_stb,
    output logic drv_seen,
    output logic oe_after_cs
);
    localparam int HALF = 80;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx_byte = 8'h00;
        rx_stb = 1'b0;
        drv_seen = 1'b0;
        oe_after_cs = 1'b1;
    end
    // Msb first, input changes on falling, answer sampled on rising
    task automatic xfer(input logic [7:0] tx[$], input int nrd, input int xb);
        logic [7:0] sh;
        int nc;
        logic line;
        sh = 8'h00;
        nc = tx.size() * 8;
        drv_seen = 1'b0;
        cs_n = 1'b0;
        for (int i = 0; i < nc + xb + nrd; i++) begin
            si = (i < nc) ? tx[i / 8][7 - i % 8] : ~si;
            #HALF sclk = 1'b1;
            // Released line floats to its pull-up level
            line = (so_oe_n === 1'b0) ? so : 1'b1;
            if (so_oe_n === 1'b0) drv_seen = 1'b1;
            sh = {sh[6:0], line};
            if (so_oe_n === 1'b0 && i >= nc + xb && (i - nc - xb) % 8 == 7) begin
                rx_byte = sh;
                rx_stb = 1'b1;
            end
            #HALF sclk = 1'b0;
            rx_stb = 1'b0;
        end
        // Gap long enough for the commit to be seen
        #HALF cs_n = 1'b1;
        #2 oe_after_cs = so_oe_n;
        si = ~si;
        #800;
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the flash command core
// Assumes: Host model drives the link; engine completion is pulsed here
// Notes: Results are noted in a queue and matched as they appear
`timescale 1ns/1ps
module tb_top;
    import flash_cmd_pkg::*;
    localparam logic [7:0] MK = 8'hA7;  // Arbitrary value
    localparam logic [15:0] PT = 16'h61C2;  // Arbitrary value
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic wr_done = 1'b0;
    logic sclk, cs_n, si, so, so_oe_n, wr_req, write_latch, busy_flag, cmd_reject;
    logic rx_stb, drv_seen, oe_after_cs;
    logic [7:0] wr_opcode, sec_reg, rx_byte;
    logic [23:0] wr_addr;
    logic [15:0] block_lock;
    logic [9:0] exp_q[$];
    logic [31:0] seed = 32'hFD90DE27;
    logic [31:0] r;
    logic [3:0] blk;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] eops[8] = '{OP_PAGE_WR, OP_QUAD_WR, OP_SECTOR_ER, OP_HALF_ER, OP_BLOCK_ER,
        OP_CHIP_ER_A, OP_CHIP_ER_B, OP_STATUS_WR};
    int elen[8] = '{5, 5, 4, 4, 4, 1, 1, 2};
    logic [7:0] mops[3] = '{OP_MP, OP_MP_DUAL, OP_MP_QUAD};
    logic [7:0] idb[3] = '{MK, PT[15:8], PT[7:0]};

    always #50 clk_sys = ~clk_sys;

    flash_cmd_core #(.MAKER_CODE(MK), .PART_CODE(PT), .NUM_BLOCKS(16)) i_flash_cmd_core (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .sclk(sclk), .cs_n(cs_n), .si(si),
        .so(so), .so_oe_n(so_oe_n), .wr_req(wr_req), .wr_opcode(wr_opcode),
        .wr_addr(wr_addr), .wr_done(wr_done), .write_latch(write_latch),
        .busy_flag(busy_flag), .cmd_reject(cmd_reject), .sec_reg(sec_reg),
        .block_lock(block_lock));
    host_model u_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
        .rx_byte(rx_byte), .rx_stb(rx_stb), .drv_seen(drv_seen), .oe_after_cs(oe_after_cs));

    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic note(input logic [1:0] k, input logic [7:0] v);
        exp_q.push_back({k, v});
    endtask
    task automatic got(input logic [9:0] v);
        if (exp_q.size() == 0) check(16'(v), 16'hFFFF, "unexpected result");
        else check(16'(v), 16'(exp_q.pop_front()), "result");
    endtask
    task automatic send(input logic [39:0] w, input int nb, input int nrd, input int xb);
        logic [7:0] fr[$];
        for (int i = 0; i < nb; i++) fr.push_back(w[39 - 8 * i -: 8]);
        u_host.xfer(fr, nrd, xb);
    endtask
    task automatic cmd(input logic [7:0] op);
        send({op, 32'h0}, 1, 0, 0);
    endtask
    task automatic stop_test();
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("ERROR %0t expected results never appeared", $time);
        end
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge rx_stb) got({2'h0, rx_byte});
    // Pulses are looked at mid-cycle, away from the edge that launches them
    always @(negedge clk_sys) begin
        if (wr_req === 1'b1) got({2'h1, wr_opcode});
        if (cmd_reject === 1'b1) got({2'h2, 8'h00});
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 check(16'(write_latch), 16'h0000, "latch after reset");
        note(2'h2, 8'h00);
        send({OP_SECTOR_ER, lfsr()}, 4, 0, 0);
        for (int i = 0; i < 8; i++) begin
            cmd(OP_LATCH_SET);
            check(16'(write_latch), 16'h0001, "latch set");
            note(2'h1, eops[i]);
            r = lfsr();
            send({eops[i], r}, elen[i], 0, 0);
            check(16'(busy_flag), 16'h0001, "busy during op");
            if (elen[i] > 2) check(wr_addr[23:8], r[31:16], "write address");
            if (elen[i] > 1) check(16'(wr_addr[7:0]),
                16'((elen[i] == 2) ? r[31:24] : r[15:8]), "write address low");
            send({OP_IDENT, 32'h0}, 1, 24, 0);
            check(16'(drv_seen), 16'h0000, "ident while busy");
            @(posedge clk_sys) wr_done <= 1'b1;
            @(posedge clk_sys) wr_done <= 1'b0;
            repeat (3) @(posedge clk_sys);
            #1 check(16'({busy_flag, write_latch}), 16'h0000, "done clears");
        end
        cmd(OP_LATCH_SET);
        cmd(OP_LATCH_CLR);
        check(16'(write_latch), 16'h0000, "latch clear");
        @(posedge clk_sys) ce <= 1'b0;
        #1 cmd(OP_LATCH_SET);
        @(posedge clk_sys) ce <= 1'b1;
        @(posedge clk_sys);
        #1 check(16'(write_latch), 16'h0000, "frame lost while frozen");
        note(2'h2, 8'h00);
        cmd(OP_ALL_LOCK);
        for (int k = 0; k < 7; k++) note(2'h0, idb[k % 3]);
        send({OP_IDENT, 32'h0}, 1, 56, 0);
        note(2'h0, MK);
        send({OP_IDENT, 32'h0}, 1, 12, 0);
        check(16'(oe_after_cs), 16'h0001, "output stops at select");
        check(16'({so_oe_n, so}), 16'h0002, "standby outputs");
        for (int i = 0; i < 3; i++) begin
            for (int a = 0; a < 2; a++) begin
                for (int k = 0; k < 4; k++) note(2'h0, ((k % 2) == a) ? MK : PT[7:0]);
                send({mops[i], 16'h0, 8'(a), 8'h0}, 4, 32, 0);
            end
        end
        for (int k = 0; k < 2; k++) note(2'h0, PT[7:0]);
        send({OP_PART, 32'h0}, 4, 16, 0);
        note(2'h0, 8'h00);
        send({OP_SEC_RD, 32'h0}, 1, 8, 0);
        cmd(OP_LATCH_SET);
        cmd(OP_SEC_WR);
        check(16'(write_latch), 16'h0000, "latch after security write");
        cmd(OP_LATCH_SET);
        cmd(OP_PROT_SEL);
        note(2'h0, 8'h82);
        send({OP_SEC_RD, 32'h0}, 1, 8, 0);
        check(16'(sec_reg), 16'h0082, "security register");
        cmd(OP_LATCH_SET);
        cmd(OP_ALL_LOCK);
        check(block_lock, 16'hFFFF, "whole lock");
        r = lfsr();
        blk = r[3:0];
        cmd(OP_LATCH_SET);
        send({OP_ONE_UNLOCK, 4'h0, blk, r[23:8], 8'h0}, 4, 0, 0);
        check(block_lock, ~(16'h0001 << blk), "single unlock");
        note(2'h0, LOCK_BYTE_OFF);
        send({OP_LOCK_RD, 4'h0, blk, r[23:8], 8'h0}, 4, 8, 0);
        note(2'h0, LOCK_BYTE_ON);
        send({OP_LOCK_RD, 4'h0, blk + 4'h1, 24'h0}, 4, 8, 0);
        cmd(OP_LATCH_SET);
        cmd(OP_ALL_UNLOCK);
        check(block_lock, 16'h0000, "whole unlock");
        cmd(OP_LATCH_SET);
        send({OP_ONE_LOCK, 4'h0, blk, r[31:16], 8'h0}, 4, 0, 0);
        check(block_lock, 16'h0001 << blk, "single lock");
        cmd(OP_LATCH_SET);
        note(2'h2, 8'h00);
        send({OP_SECTOR_ER, lfsr()}, 4, 0, 3);
        check(16'(write_latch), 16'h0001, "partial frame refused");
        @(posedge clk_sys) resetn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 check(16'(write_latch), 16'h0000, "latch after second reset");
        stop_test();
    end
endmodule
